// ### hw/tbo_ctrl.v
// touch button output controller: four touch states to active-low outputs
// assumes touch detection and self-test measurements arrive from the
// analog front end; touch and grounded sense pins are sampled by two flip-flops
// What this block does
// - straps captured once after reset release
// - grounded sense input disables its button
// - each output follows its own input
// - outputs active low, driven once straps are captured
// - failed button: 5 ms pulse at 175 ms
// - deep sleep drives all outputs high, except during the fault pulse
// - low-power sleep freezes output levels, except during the fault pulse
// - outputs high impedance during reset
// - toggle inverts output per new touch
// - suppression: single touch reported active
// - suppression: keep earlier touched button only
// - led hold keeps output low after release
// - hold range 0 to 2000 ms, 20 ms steps
// - new release cancels running hold elsewhere
// - no led hold after auto release
// - auto release after continuous touch period
// - auto release period 5 or 20 s
// - power_on_self_test-release hold 220 ms or scan plus 200
// - self-test disables shorts to ground or supply
// - shorted button group all disabled
// - bad modulator capacitor disables all buttons
// - parasitic capacitance above 40 pF disables button
`timescale 1ns/1ns
`include "tbo_defs.vh"
module tbo_ctrl
#(
  parameter MS_CYC = `TBO_MS_CYC
)
(
  input  wire        core_clk,
  input  wire        resetn,
  input  wire [3:0]  sense_touch,
  input  wire [3:0]  sense_grounded,
  input  wire [3:0]  power_on_self_test_short_gnd,
  input  wire [3:0]  power_on_self_test_short_vdd,
  input  wire [3:0]  power_on_self_test_short_group,
  input  wire [15:0] modulator_capacitor_pf,
  input  wire [31:0] power_on_self_test_cp_pf,
  input  wire        strap_toggle,
  input  wire        neighbour_suppression,
  input  wire [6:0]  strap_hold_steps,
  input  wire        auto_release_strap,
  input  wire        strap_release_long,
  input  wire [7:0]  scan_interval,
  input  wire        sleep_req,
  input  wire        deep_sleep_req,
  output reg  [3:0]  button_output_n,
  output reg  [3:0]  button_output_oe_n,
  output reg  [3:0]  button_disabled_q
);
  localparam ST_POWER_ON_SELF_TEST = 3'b001;
  localparam ST_RUN  = 3'b010;
  localparam ST_DONE = 3'b100;

  // ==========================================================
  // input synchronisers
  reg [3:0]  t_s1_q, t_s2_q, g_s1_q, g_s2_q;
  reg        sl_s1_q, sl_s2_q, dp_s1_q, dp_s2_q;
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      t_s1_q  <= 4'h0;
      t_s2_q  <= 4'h0;
      g_s1_q  <= 4'h0;
      g_s2_q  <= 4'h0;
      sl_s1_q <= 1'b0;
      sl_s2_q <= 1'b0;
      dp_s1_q <= 1'b0;
      dp_s2_q <= 1'b0;
    end
    else
    begin
      t_s1_q  <= sense_touch;
      t_s2_q  <= t_s1_q;
      g_s1_q  <= sense_grounded;
      g_s2_q  <= g_s1_q;
      sl_s1_q <= sleep_req;
      sl_s2_q <= sl_s1_q;
      dp_s1_q <= deep_sleep_req;
      dp_s2_q <= dp_s1_q;
    end
  end

  wire ms_tick;
  tbo_tick #(.MS_CYC(MS_CYC)) u_tick
  (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .ms_tick_q (ms_tick)
  );

  // ==========================================================
  // strap capture and self-test
  reg [2:0]            st_q;
  reg [`TBO_POWER_ON_SELF_TEST_W-1:0] power_on_self_test_ms_q;
  reg                  cap_done_q;
  reg                  tog_q, fss_q, ar_q, arl_q;
  reg [6:0]            hold_steps_q;
  reg [7:0]            scan_q;
  reg [3:0]            fail_q;
  reg [3:0]            cp_bad;
  integer              k;
  always @*
  begin
    for (k = 0; k < 4; k = k + 1)
      cp_bad[k] = power_on_self_test_cp_pf[k*8 +: 8] > `TBO_CP_MAX_PF;
  end
  wire cmod_bad = (modulator_capacitor_pf < `TBO_CMOD_MIN_PF) |
                  (modulator_capacitor_pf > `TBO_CMOD_MAX_PF);

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q         <= ST_POWER_ON_SELF_TEST;
      power_on_self_test_ms_q    <= {`TBO_POWER_ON_SELF_TEST_W{1'b0}};
      cap_done_q   <= 1'b0;
      tog_q        <= 1'b0;
      fss_q        <= 1'b0;
      ar_q         <= 1'b0;
      arl_q        <= 1'b0;
      hold_steps_q <= 7'h00;
      scan_q       <= 8'h00;
      fail_q       <= 4'h0;
      button_disabled_q <= 4'h0;
    end
    else
    begin
      if (!cap_done_q)
      begin
        cap_done_q   <= 1'b1;
        tog_q        <= strap_toggle;
        fss_q        <= neighbour_suppression;
        ar_q         <= auto_release_strap;
        arl_q        <= strap_release_long;
        hold_steps_q <= (strap_hold_steps > `TBO_HOLD_MAX_STEPS) ?
                        `TBO_HOLD_MAX_STEPS : strap_hold_steps;
        scan_q       <= (scan_interval == 8'h00) ? 8'h01 : scan_interval;
        fail_q       <= power_on_self_test_short_gnd | power_on_self_test_short_vdd |
                        power_on_self_test_short_group | cp_bad |
                        {4{cmod_bad}};
        button_disabled_q <= power_on_self_test_short_gnd | power_on_self_test_short_vdd |
                             power_on_self_test_short_group | cp_bad |
                             {4{cmod_bad}};
      end
      if (ms_tick && st_q != ST_DONE)
        power_on_self_test_ms_q <= power_on_self_test_ms_q + 1'b1;
      case (st_q)
        ST_POWER_ON_SELF_TEST:
          if (power_on_self_test_ms_q == `TBO_FAULT_START_MS)
            st_q <= ST_RUN;
        ST_RUN:
          if (power_on_self_test_ms_q == `TBO_FAULT_START_MS + `TBO_FAULT_LEN_MS)
            st_q <= ST_DONE;
        ST_DONE:
          st_q <= ST_DONE;
        default:
          st_q <= ST_POWER_ON_SELF_TEST;
      endcase
    end
  end

  // ==========================================================
  // scan divider: one pulse per scan interval
  reg [7:0] scan_ms_q;
  reg       scan_q_tick;
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scan_ms_q   <= 8'h00;
      scan_q_tick <= 1'b0;
    end
    else
    begin
      scan_q_tick <= 1'b0;
      if (ms_tick)
      begin
        if (scan_ms_q + 8'h01 >= scan_q)
        begin
          scan_ms_q   <= 8'h00;
          scan_q_tick <= 1'b1;
        end
        else
          scan_ms_q <= scan_ms_q + 8'h01;
      end
    end
  end

  // ==========================================================
  // per-scan touch processing
  // blind after an auto release: touches ignored until its hold ends
  reg  [3:0] arhold_q;
  wire [3:0] raw = t_s2_q & ~button_disabled_q & ~g_s2_q &
                   ~arhold_q;
  reg  [3:0] prev_q;
  reg  [3:0] rep;
  reg  [2:0] nhot;
  integer    j;
  always @*
  begin
    nhot = 3'd0;
    for (j = 0; j < 4; j = j + 1)
      nhot = nhot + {2'b00, raw[j]};
    if (!fss_q || nhot < 3'd2)
      rep = raw;
    else
      rep = raw & prev_q;
  end

  wire [`TBO_T_W-1:0] ar_period = arl_q ? `TBO_AR_LONG_MS :
                                          `TBO_AR_SHORT_MS;
  wire [`TBO_T_W-1:0] scan_ms16 = {8'h00, scan_q};
  wire [`TBO_T_W-1:0] hold_ms = hold_steps_q * `TBO_HOLD_STEP_MS;
  wire [3:0] fall = prev_q & ~rep;
  wire       any_fall = |fall;
  wire       run_ok = st_q != ST_POWER_ON_SELF_TEST && cap_done_q;

  reg [3:0] act_q, tog_st_q, arfired_q, hold_on_q;
  reg [`TBO_T_W-1:0] tch_ms_q [0:3];
  reg [`TBO_T_W-1:0] hold_ms_q [0:3];
  reg [`TBO_T_W-1:0] ar_lim_q [0:3];

  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1)
    begin : g_btn
      always @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          prev_q[b]    <= 1'b0;
          tog_st_q[b]  <= 1'b0;
          arfired_q[b] <= 1'b0;
          hold_on_q[b] <= 1'b0;
          arhold_q[b]  <= 1'b0;
          act_q[b]     <= 1'b0;
          tch_ms_q[b]  <= {`TBO_T_W{1'b0}};
          hold_ms_q[b] <= {`TBO_T_W{1'b0}};
          ar_lim_q[b]  <= {`TBO_T_W{1'b0}};
        end
        else if (scan_q_tick && run_ok && !sl_s2_q && !dp_s2_q)
        begin
          prev_q[b] <= rep[b];
          // touch duration counter
          if (rep[b])
            tch_ms_q[b] <= tch_ms_q[b] + scan_ms16;
          else
            tch_ms_q[b] <= {`TBO_T_W{1'b0}};
          if (ar_q && rep[b] && !arfired_q[b] &&
              tch_ms_q[b] + scan_ms16 >= ar_period)
          begin
            arfired_q[b] <= 1'b1;
            tch_ms_q[b]  <= {`TBO_T_W{1'b0}};
          end
          if (rep[b] && !prev_q[b])
            tog_st_q[b] <= ~tog_st_q[b];
          // hold after release
          if (fall[b] && arfired_q[b])
          begin
            arfired_q[b] <= 1'b0;
            arhold_q[b]  <= 1'b1;
            hold_on_q[b] <= 1'b0;
            hold_ms_q[b] <= {`TBO_T_W{1'b0}};
            ar_lim_q[b]  <= (tch_ms_q[b] < `TBO_AR_QUICK_MS) ?
                            `TBO_AR_HOLD_Q_MS :
                            scan_ms16 + `TBO_AR_HOLD_ADD_MS;
          end
          else if (fall[b])
          begin
            hold_on_q[b] <= hold_steps_q != 7'h00;
            hold_ms_q[b] <= {`TBO_T_W{1'b0}};
          end
          else if (any_fall && hold_on_q[b])
            hold_on_q[b] <= 1'b0;
          else if (hold_on_q[b])
          begin
            if (hold_ms_q[b] + scan_ms16 >= hold_ms)
              hold_on_q[b] <= 1'b0;
            hold_ms_q[b] <= hold_ms_q[b] + scan_ms16;
          end
          if (arhold_q[b] && !fall[b])
          begin
            if (hold_ms_q[b] + scan_ms16 >= ar_lim_q[b])
              arhold_q[b] <= 1'b0;
            hold_ms_q[b] <= hold_ms_q[b] + scan_ms16;
          end
          // output state for this button only
          if (tog_q)
            act_q[b] <= tog_st_q[b] ^ (rep[b] & ~prev_q[b]);
          else
            act_q[b] <= (rep[b] & ~arfired_q[b] &
                         ~(ar_q && tch_ms_q[b] + scan_ms16 >= ar_period))
                        | (hold_on_q[b] & ~fall[b] & ~any_fall &
                           (hold_ms_q[b] + scan_ms16 < hold_ms))
                        | (fall[b] & ~arfired_q[b] &
                           (hold_steps_q != 7'h00));
        end
      end

      // pin driver
      always @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          button_output_n[b]    <= 1'b1;
          button_output_oe_n[b] <= 1'b1;
        end
        else if (!cap_done_q)
        begin
          button_output_n[b]    <= 1'b1;
          button_output_oe_n[b] <= 1'b1;
        end
        else
        begin
          button_output_oe_n[b] <= 1'b0;
          if (st_q == ST_RUN)
            button_output_n[b] <= ~fail_q[b];
          else if (st_q == ST_POWER_ON_SELF_TEST || fail_q[b] || dp_s2_q)
            button_output_n[b] <= 1'b1;
          else if (sl_s2_q)
            button_output_n[b] <= button_output_n[b];
          else
            button_output_n[b] <= ~act_q[b];
        end
      end
    end
  endgenerate
endmodule // tbo_ctrl

// ### hw/tbo_defs.vh
// constants for the touch button output controller
// assumes a 25 MHz core clock; included by the design files
`ifndef TBO_DEFS_VH
`define TBO_DEFS_VH
// one ms tick per millisecond: 1 ms at 40 ns
`define TBO_MS_NS          1000000
`define TBO_CLK_NS         40
`define TBO_MS_CYC         (`TBO_MS_NS / `TBO_CLK_NS)
`define TBO_MS_W           15
// power-on fault pulse timing in ms
`define TBO_FAULT_START_MS 12'd175
`define TBO_FAULT_LEN_MS   12'd5
`define TBO_POWER_ON_SELF_TEST_W         12
// led hold: step in ms, max steps (2000 / 20)
`define TBO_HOLD_STEP_MS   16'd20
`define TBO_HOLD_MAX_STEPS 7'd100
// auto release periods and after-release hold in ms
`define TBO_AR_SHORT_MS    16'd5000
`define TBO_AR_LONG_MS     16'd20000
`define TBO_AR_QUICK_MS    16'd2000
`define TBO_AR_HOLD_Q_MS   16'd220
`define TBO_AR_HOLD_ADD_MS 16'd200
`define TBO_T_W            16
// modulator and parasitic capacitor limits in pF
`define TBO_CMOD_MIN_PF    16'd1000
`define TBO_CMOD_MAX_PF    16'd4000
`define TBO_CP_MAX_PF      8'd40
`endif

// ### hw/tbo_tick.v
// millisecond enable divider
// assumes the core clock of the defs header
`timescale 1ns/1ns
`include "tbo_defs.vh"
module tbo_tick
#(
  parameter MS_CYC = `TBO_MS_CYC
)
(
  input  wire core_clk,
  input  wire resetn,
  output reg  ms_tick_q
);
  localparam [31:0]          LAST_W = MS_CYC - 1;
  localparam [`TBO_MS_W-1:0] LAST   = LAST_W[`TBO_MS_W-1:0];
  reg [`TBO_MS_W-1:0] cnt_q;

  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q     <= {`TBO_MS_W{1'b0}};
      ms_tick_q <= 1'b0;
    end
    else
    begin
      ms_tick_q <= (cnt_q == LAST);
      if (cnt_q == LAST)
        cnt_q <= {`TBO_MS_W{1'b0}};
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule // tbo_tick

// ### testbench/tbo_ctrl_assertions.sv
// port checker for tbo_ctrl
// assumes a 25 MHz core_clk; bound to every tbo_ctrl
`timescale 1ns/1ns
module tbo_ctrl_chk
#(
  parameter int MS = 25000
)
(
  input wire       core_clk,
  input wire       resetn,
  input wire [3:0] sense_touch,
  input wire [3:0] sense_grounded,
  input wire       sleep_req,
  input wire       deep_sleep_req,
  input wire [3:0] button_output_n,
  input wire [3:0] button_output_oe_n,
  input wire [3:0] button_disabled_q
);
  reg [31:0] up_q;
  always @(posedge core_clk or negedge resetn)
    if (!resetn)
      up_q <= 32'h0;
    else if (up_q != 32'hffffffff)
      up_q <= up_q + 32'h1;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_rel_hiz;
    up_q == 0 |-> button_output_oe_n == 4'hf;
  endproperty
  a_rel_hiz: assert property (p_rel_hiz) else $error("pins driven at release");
  property p_driven;
    up_q > 3 |-> button_output_oe_n == 4'h0;
  endproperty
  a_driven: assert property (p_driven) else $error("pin not driven");
  property p_quiet;
    up_q > 3 && up_q < 174 * MS |-> button_output_n == 4'hf;
  endproperty
  a_quiet: assert property (p_quiet) else $error("output low too early");
  property p_pulse;
    up_q > 176 * MS && up_q < 179 * MS
      |-> (~button_output_n | sense_grounded | ~button_disabled_q) == 4'hf;
  endproperty
  a_pulse: assert property (p_pulse) else $error("fault pulse missing");
  property p_after;
    up_q > 181 * MS
      |-> (~button_output_n & (button_disabled_q | sense_grounded)) == 4'h0;
  endproperty
  a_after: assert property (p_after) else $error("dead button low");
  property p_deep;
    deep_sleep_req [*6] |-> button_output_n == 4'hf;
  endproperty
  a_deep: assert property (p_deep) else $error("deep sleep not high");
  property p_sleep;
    (sleep_req && !deep_sleep_req) [*6] |-> $stable(button_output_n);
  endproperty
  a_sleep: assert property (p_sleep) else $error("level moved in sleep");
  property p_dis_fix;
    up_q > 3 |-> $stable(button_disabled_q);
  endproperty
  a_dis_fix: assert property (p_dis_fix) else $error("disable set moved");
  property p_own;
    $fell(button_output_n[0]) && up_q > 181 * MS |-> sense_touch[0];
  endproperty
  a_own: assert property (p_own) else $error("output 0 low untouched");
  c_deep: cover property (deep_sleep_req [*6]);
  c_pulse: cover property (up_q == 177 * MS && button_output_n != 4'hf);
  c_fall: cover property ($fell(button_output_n[0]));
endmodule // tbo_ctrl_chk
bind tbo_ctrl tbo_ctrl_chk #(.MS(MS_CYC)) i_tbo_ctrl_chk (.core_clk(core_clk),
  .resetn(resetn), .sense_touch(sense_touch),
  .sense_grounded(sense_grounded), .sleep_req(sleep_req),
  .deep_sleep_req(deep_sleep_req), .button_output_n(button_output_n),
  .button_output_oe_n(button_output_oe_n),
  .button_disabled_q(button_disabled_q));

// ### testbench/tbo_pad_model.sv
// touch pads and leds on the controller pins
// assumes each led pulls its pin up to the supply
`timescale 1ns/1ns
module tbo_pad_model
(
  input  wire [3:0] touch_cmd,
  input  wire [3:0] button_output_n,
  input  wire [3:0] button_output_oe_n,
  output wire [3:0] sense_touch,
  output wire [3:0] pin_level
);
  assign sense_touch = touch_cmd;
  // released pin floats up through the led
  assign pin_level = button_output_n | button_output_oe_n;
endmodule // tbo_pad_model

// ### testbench/tb_touch_button_output_control.sv
// bench for the touch button output controller
// assumes design, pad model and checker compiled first
`timescale 1ns/1ns
module tb_touch_button_output_control;
  // one millisecond shortened to keep the run brief
  localparam int MS = 10;
  reg         core_clk = 1'b0;
  reg         resetn = 1'b0;
  reg  [3:0]  touch_cmd = 4'h0;
  reg  [3:0]  gnd_in = 4'h8;
  reg  [3:0]  sh_g = 4'h0;
  reg  [3:0]  sh_v = 4'h0;
  reg  [3:0]  sh_s = 4'h0;
  reg  [15:0] cmod = 16'h0898;
  reg  [31:0] cp = 32'h0a0a0a0a;
  reg         tog = 1'b0;
  reg         sup = 1'b1;
  reg         ar = 1'b0;
  reg         slp = 1'b0;
  reg         dslp = 1'b0;
  wire [3:0]  touch;
  wire [3:0]  out_n;
  wire [3:0]  oe_n;
  wire [3:0]  dis;
  wire [3:0]  pin;
  integer     err_count = 0;
  integer     n_compared = 0;
  always #20 core_clk = ~core_clk;
  tbo_ctrl #(.MS_CYC(MS)) i_tbo_ctrl (.core_clk(core_clk), .resetn(resetn),
    .sense_touch(touch), .sense_grounded(gnd_in), .power_on_self_test_short_gnd(sh_g),
    .power_on_self_test_short_vdd(sh_v), .power_on_self_test_short_group(sh_s),
    .modulator_capacitor_pf(cmod), .power_on_self_test_cp_pf(cp), .strap_toggle(tog),
    .neighbour_suppression(sup), .strap_hold_steps(7'h01),
    .auto_release_strap(ar), .strap_release_long(1'b0),
    .scan_interval(8'h01), .sleep_req(slp), .deep_sleep_req(dslp),
    .button_output_n(out_n), .button_output_oe_n(oe_n),
    .button_disabled_q(dis));
  tbo_pad_model i_tbo_pad_model (.touch_cmd(touch_cmd),
    .button_output_n(out_n), .button_output_oe_n(oe_n),
    .sense_touch(touch), .pin_level(pin));
  // ======================================
  // shared tasks
  task chk(input [3:0] got, input [3:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wait_ms(input integer n);
    begin
      repeat (n * MS) @(posedge core_clk);
      #1;
    end
  endtask
  task press(input [3:0] t, input integer n);
    begin
      @(posedge core_clk);
      touch_cmd <= t;
      wait_ms(n);
    end
  endtask
  task cfg(input [3:0] g, v, s, input [15:0] c, input [31:0] p,
           input [3:0] exp);
    begin
      @(posedge core_clk);
      resetn <= 1'b0;
      slp <= 1'b0;
      dslp <= 1'b0;
      sh_g <= g;
      sh_v <= v;
      sh_s <= s;
      cmod <= c;
      cp <= p;
      repeat (16) @(posedge core_clk);
      #1;
      chk(oe_n, 4'hf);
      chk(pin, 4'hf);
      @(posedge core_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge core_clk);
      #1;
      chk(oe_n, 4'h0);
      chk({1'b0, dis[2:0]}, exp);
    end
  endtask
  task wrap_up;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial
  begin
    repeat (7000 * MS) @(posedge core_clk);
    err_count = err_count + 1;
    wrap_up;
  end
  initial
  begin
    cfg(4'h0, 4'h4, 4'h0, 16'h0898, 32'h0a0a0a0a, 4'h4);
    cfg(4'h0, 4'h0, 4'h5, 16'h0898, 32'h0a0a0a0a, 4'h5);
    cfg(4'h0, 4'h0, 4'h0, 16'h03e7, 32'h0a0a0a0a, 4'h7);
    cfg(4'h0, 4'h0, 4'h0, 16'h0fa1, 32'h0a0a0a0a, 4'h7);
    cfg(4'h0, 4'h0, 4'h0, 16'h03e8, 32'h0a0a0a29, 4'h1);
    cfg(4'h0, 4'h0, 4'h0, 16'h0fa0, 32'h0a0a0a28, 4'h0);
    cfg(4'h2, 4'h0, 4'h0, 16'h0898, 32'h0a0a0a0a, 4'h2);
    wait_ms(177);
    chk(pin, 4'hd);
    wait_ms(5);
    chk(pin, 4'hf);
    press(4'h1, 3);
    chk(pin, 4'he);
    press(4'h5, 3);
    chk(pin, 4'he);
    press(4'h0, 3);
    chk(pin, 4'he);
    wait_ms(25);
    chk(pin, 4'hf);
    press(4'h1, 3);
    press(4'h0, 2);
    press(4'h4, 3);
    chk(pin, 4'ha);
    press(4'h0, 2);
    chk(pin, 4'hb);
    wait_ms(25);
    press(4'h1, 3);
    @(posedge core_clk);
    slp <= 1'b1;
    press(4'h0, 3);
    chk(pin, 4'he);
    @(posedge core_clk);
    dslp <= 1'b1;
    wait_ms(1);
    chk(pin, 4'hf);
    @(posedge core_clk);
    tog <= 1'b1;
    sup <= 1'b0;
    cfg(4'h0, 4'h0, 4'h0, 16'h0898, 32'h0a0a0a0a, 4'h0);
    wait_ms(182);
    press(4'h1, 3);
    press(4'h0, 3);
    chk(pin, 4'he);
    press(4'h1, 3);
    press(4'h0, 3);
    chk(pin, 4'hf);
    // auto release with the short period, then the blind hold
    @(posedge core_clk);
    tog <= 1'b0;
    ar <= 1'b1;
    cfg(4'h0, 4'h0, 4'h0, 16'h0898, 32'h0a0a0a0a, 4'h0);
    wait_ms(182);
    press(4'h1, 4990);
    chk(pin, 4'he);
    wait_ms(20);
    chk(pin, 4'hf);
    press(4'h0, 3);
    chk(pin, 4'hf);
    press(4'h1, 100);
    chk(pin, 4'hf);
    press(4'h0, 150);
    press(4'h1, 3);
    chk(pin, 4'he);
    wrap_up;
  end
endmodule // tb_touch_button_output_control
